// File: rtl/dsaoc_regs.svh
// constants of the integrating converter control block: counts, timings
// assumes a 20 MHz system clock and a slow external conversion oscillator
`ifndef DSAOC_REGS_SVH
`define DSAOC_REGS_SVH

// conversion counts, in conversion clock ticks
`define DSAOC_FRAME_COUNTS 8192
`define DSAOC_INT_COUNTS   2048
`define DSAOC_DEINT_MAX    4096
`define DSAOC_HALT_EARLY   7

// crystal mode divides the buffered oscillator by this ratio
`define DSAOC_XTAL_DIV     58

// system clock period and load strobe width, in ns
`define DSAOC_CLK_NS       50
`define DSAOC_LOAD_NS      200
`define DSAOC_LOAD_CYC     ((`DSAOC_LOAD_NS + `DSAOC_CLK_NS - 1) / `DSAOC_CLK_NS)

// synchroniser reset: each pin at its idle level, so no false request follows reset
// bits: high_byte_enable_n, low_byte_enable_n, strobe, accept, comparator, mode, test, run, osc select
`define DSAOC_PIN_IDLE     9'h1e6

// mode pulse least width, in ns
`define DSAOC_MODE_PULSE_NS 50

`endif

// File: rtl/dsaoc_pkg.sv
// types of the integrating converter control block
// assumes dsaoc_regs.svh carries the numeric constants
package dsaoc_pkg;

    typedef struct packed {
        logic        sign;
        logic        excess;
        logic [11:0] magnitude;
    } dsaoc_result_t;

    typedef enum logic [1:0] {
        DSAOC_PH_NULL,
        DSAOC_PH_INT,
        DSAOC_PH_REF
    } dsaoc_phase_t;

    typedef enum logic [2:0] {
        DSAOC_HS_IDLE,
        DSAOC_HS_WAIT_HI,
        DSAOC_HS_HI,
        DSAOC_HS_WAIT_LO,
        DSAOC_HS_LO
    } dsaoc_hs_t;

endpackage

// File: rtl/dsaoc_ctrl.sv
// conversion sequencer and result port of a 12-bit integrating converter
// assumes pins arrive unsynchronised; the analog comparator is an input pin
`include "dsaoc_regs.svh"

// What this block does
// (R1) status high through integrate and deintegrate until latch
// (R2) status low during null phase
// (R3) sign high for positive, excess on overrange
// (R4) magnitude is 12-bit binary, bit 12 msb
// (R5) test low forces all result bits high; the code forces only the 12 magnitude bits, not sign or excess
// (R6) strobe and low enable low drive low byte
// (R7) strobe and high enable low drive high byte
// (R8) chip strobe gates result outputs in direct mode
// (R9) strobe high floats all result outputs
// (R10) mode high turns byte enables into flag outputs
// (R11) mode high drives chip strobe as load strobe
// (R12) mode low: strobe and enables are inputs; the code keeps them outputs until a handshake started by a mode pulse ends
// (R13) mode pulse sends latched result at once
// (R14) mode held high sends each finished conversion
// (R15) oscillator select low divides by 58
// (R16) oscillator select high uses oscillator directly
// (R17) run high converts every 8192 counts
// (R18) run low halts 7 counts before integrate
// (R19) receiver raises accept when it takes data
// (R20) integrate lasts 2048 counts then latches polarity
// (R21) high byte then low byte, each awaiting accept
module dsaoc_ctrl #(
    parameter int FRAME_COUNTS = `DSAOC_FRAME_COUNTS,
    parameter int INT_COUNTS   = `DSAOC_INT_COUNTS,
    parameter int DEINT_MAX    = `DSAOC_DEINT_MAX,
    parameter int HALT_EARLY   = `DSAOC_HALT_EARLY,
    parameter int XTAL_DIV     = `DSAOC_XTAL_DIV,
    parameter int LOAD_CYC     = `DSAOC_LOAD_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   osc_buf,
    input  wire logic                   osc_sel,
    input  wire logic                   run,
    input  wire logic                   test_n,
    input  wire logic                   mode,
    input  wire logic                   comparator,
    input  wire logic                   accept,
    input  wire logic                   chip_strobe_n_in,
    output logic                        chip_strobe_n_out,
    output logic                        chip_strobe_n_oe,
    input  wire logic                   low_byte_enable_n_in,
    output logic                        low_byte_enable_n_out,
    output logic                        low_byte_enable_n_oe,
    input  wire logic                   high_byte_enable_n_in,
    output logic                        high_byte_enable_n_out,
    output logic                        high_byte_enable_n_oe,
    output dsaoc_pkg::dsaoc_result_t    result,
    output logic                        result_lo_oe,
    output logic                        result_hi_oe,
    output logic                        status
);

    localparam int CW = $clog2(FRAME_COUNTS);
    localparam int DW = $clog2(XTAL_DIV);
    localparam int LW = $clog2(LOAD_CYC + 1);

    initial begin
        if (FRAME_COUNTS < INT_COUNTS + DEINT_MAX + HALT_EARLY + 1 || DEINT_MAX > 4096 || XTAL_DIV < 2
            || LOAD_CYC < 1 || HALT_EARLY < 1) begin
            $error("dsaoc_ctrl: unsupported parameter values");
        end
    end

    // pins from outside the clock domain, two flops before any use
    localparam int NIN = 9;
    logic [NIN-1:0] pin_meta_q;
    logic [NIN-1:0] pin_sync_q;
    logic           osc_s;
    logic           osc_sel_s;
    logic           run_s;
    logic           test_n_s;
    logic           mode_s;
    logic           comp_s;
    logic           accept_s;
    logic           ce_n_s;
    logic           low_byte_enable_n_n_s;
    logic           high_byte_enable_n_n_s;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_q <= `DSAOC_PIN_IDLE;
            pin_sync_q <= `DSAOC_PIN_IDLE;
        end else begin
            pin_meta_q <= {high_byte_enable_n_in, low_byte_enable_n_in, chip_strobe_n_in, accept, comparator,
                           mode, test_n, run, osc_sel};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign osc_sel_s = pin_sync_q[0];
    assign run_s     = pin_sync_q[1];
    assign test_n_s  = pin_sync_q[2];
    assign mode_s    = pin_sync_q[3];
    assign comp_s    = pin_sync_q[4];
    assign accept_s  = pin_sync_q[5];
    assign ce_n_s    = pin_sync_q[6];
    assign low_byte_enable_n_n_s  = pin_sync_q[7];
    assign high_byte_enable_n_n_s  = pin_sync_q[8];

    logic osc_meta_q;
    logic osc_sync_q;
    logic osc_prev_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_meta_q <= 1'b0;
            osc_sync_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            osc_meta_q <= osc_buf;
            osc_sync_q <= osc_meta_q;
            osc_prev_q <= osc_sync_q;
        end
    end
    assign osc_s = osc_sync_q;

    // conversion tick: every oscillator rising edge, or every 58th rising edge with a crystal
    logic [DW-1:0] div_q;
    logic          tick_q;
    logic          osc_rise;
    assign osc_rise = osc_s & ~osc_prev_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (osc_rise) begin
                if (osc_sel_s) begin
                    div_q  <= '0;
                    tick_q <= 1'b1; // R16
                end else if (div_q == DW'(XTAL_DIV - 1)) begin
                    div_q  <= '0;
                    tick_q <= 1'b1; // R15
                end else begin
                    div_q <= div_q + 1'b1;
                end
            end
        end
    end

    // phase sequencer; the frame counter spans one whole conversion
    dsaoc_pkg::dsaoc_phase_t phase_q;
    logic [CW-1:0]           cnt_q;
    logic [12:0]             ref_q;
    logic                    pol_q;
    logic                    done_q;
    dsaoc_pkg::dsaoc_result_t latched_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_q   <= dsaoc_pkg::DSAOC_PH_NULL;
            cnt_q     <= '0;
            ref_q     <= '0;
            pol_q     <= 1'b0;
            done_q    <= 1'b0;
            latched_q <= '0;
        end else begin
            done_q <= 1'b0;
            if (tick_q) begin
                case (phase_q)
                    dsaoc_pkg::DSAOC_PH_NULL: begin
                        if (cnt_q == CW'(FRAME_COUNTS - 1)) begin
                            cnt_q   <= '0;
                            phase_q <= dsaoc_pkg::DSAOC_PH_INT; // R17
                        end else if (!run_s && cnt_q == CW'(FRAME_COUNTS - HALT_EARLY)) begin
                            cnt_q <= cnt_q; // R18
                        end else begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    dsaoc_pkg::DSAOC_PH_INT: begin
                        cnt_q <= cnt_q + 1'b1;
                        if (cnt_q == CW'(INT_COUNTS - 1)) begin
                            phase_q <= dsaoc_pkg::DSAOC_PH_REF; // R20
                            pol_q   <= comp_s; // R20
                            ref_q   <= '0;
                        end
                    end
                    dsaoc_pkg::DSAOC_PH_REF: begin
                        cnt_q <= cnt_q + 1'b1;
                        if (comp_s != pol_q) begin
                            // zero crossing: the count so far is the magnitude
                            latched_q.sign      <= pol_q; // R3
                            latched_q.excess    <= 1'b0;
                            latched_q.magnitude <= ref_q[11:0]; // R4
                            phase_q             <= dsaoc_pkg::DSAOC_PH_NULL;
                            done_q              <= 1'b1;
                        end else if (ref_q == 13'(DEINT_MAX - 1)) begin
                            latched_q.sign      <= pol_q;
                            latched_q.excess    <= 1'b1; // R3
                            latched_q.magnitude <= 12'hfff;
                            phase_q             <= dsaoc_pkg::DSAOC_PH_NULL;
                            done_q              <= 1'b1;
                        end else begin
                            ref_q <= ref_q + 1'b1;
                        end
                    end
                    default: begin
                        phase_q <= dsaoc_pkg::DSAOC_PH_NULL;
                    end
                endcase
            end
        end
    end

    // status follows the phase; the latch and the return to null coincide
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status <= 1'b0;
        end else begin
            status <= (phase_q != dsaoc_pkg::DSAOC_PH_NULL); // R1 R2
        end
    end

    // handshake sequencer; a mode pulse shorter than a clock may be missed
    dsaoc_pkg::dsaoc_hs_t hs_q;
    logic [LW-1:0]        load_q;
    logic                 mode_prev_q;
    logic                 hs_start;
    assign hs_start = (mode_s & ~mode_prev_q) | (mode_s & done_q); // R13 R14

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hs_q        <= dsaoc_pkg::DSAOC_HS_IDLE;
            load_q      <= '0;
            mode_prev_q <= 1'b0;
        end else begin
            mode_prev_q <= mode_s;
            case (hs_q)
                dsaoc_pkg::DSAOC_HS_IDLE: begin
                    if (hs_start) begin
                        hs_q <= dsaoc_pkg::DSAOC_HS_WAIT_HI;
                    end
                end
                dsaoc_pkg::DSAOC_HS_WAIT_HI: begin
                    if (accept_s) begin
                        hs_q   <= dsaoc_pkg::DSAOC_HS_HI; // R21
                        load_q <= LW'(LOAD_CYC);
                    end
                end
                dsaoc_pkg::DSAOC_HS_HI: begin
                    load_q <= load_q - 1'b1;
                    if (load_q == LW'(1)) begin
                        hs_q <= dsaoc_pkg::DSAOC_HS_WAIT_LO;
                    end
                end
                dsaoc_pkg::DSAOC_HS_WAIT_LO: begin
                    if (accept_s) begin
                        hs_q   <= dsaoc_pkg::DSAOC_HS_LO; // R21
                        load_q <= LW'(LOAD_CYC);
                    end
                end
                dsaoc_pkg::DSAOC_HS_LO: begin
                    load_q <= load_q - 1'b1;
                    if (load_q == LW'(1)) begin
                        hs_q <= dsaoc_pkg::DSAOC_HS_IDLE;
                    end
                end
                default: begin
                    hs_q <= dsaoc_pkg::DSAOC_HS_IDLE;
                end
            endcase
        end
    end

    // pin drive: in handshake the three control pins become outputs
    logic       hs_drive;
    logic       in_hi;
    logic       in_lo;
    logic [2:0] drv_hist_q;
    assign hs_drive = mode_s | (hs_q != dsaoc_pkg::DSAOC_HS_IDLE);
    assign in_hi    = (hs_q == dsaoc_pkg::DSAOC_HS_HI);
    assign in_lo    = (hs_q == dsaoc_pkg::DSAOC_HS_LO);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chip_strobe_n_oe       <= 1'b0;
            chip_strobe_n_out      <= 1'b1;
            low_byte_enable_n_oe   <= 1'b0;
            low_byte_enable_n_out  <= 1'b1;
            high_byte_enable_n_oe  <= 1'b0;
            high_byte_enable_n_out <= 1'b1;
            drv_hist_q             <= 3'h0;
        end else begin
            drv_hist_q             <= {drv_hist_q[1:0], hs_drive};
            low_byte_enable_n_oe   <= hs_drive; // R10 R12
            high_byte_enable_n_oe  <= hs_drive; // R10 R12
            chip_strobe_n_oe       <= hs_drive; // R11 R12
            high_byte_enable_n_out <= ~in_hi; // R10
            low_byte_enable_n_out  <= ~in_lo; // R10
            chip_strobe_n_out      <= ~(in_hi | in_lo); // R11
        end
    end

    // result pins; direct mode decodes the host's strobe and byte enables
    logic direct;
    // our own strobe and flags linger in the synchronisers for three clocks after release
    assign direct = ~hs_drive & ~|drv_hist_q; // R12

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result       <= '0;
            result_lo_oe <= 1'b0;
            result_hi_oe <= 1'b0;
        end else begin
            result.sign      <= latched_q.sign;
            result.excess    <= latched_q.excess;
            result.magnitude <= test_n_s ? latched_q.magnitude : 12'hfff; // R5
            result_lo_oe     <= (direct & ~ce_n_s & ~low_byte_enable_n_n_s) | in_lo; // R6 R8 R9
            result_hi_oe     <= (direct & ~ce_n_s & ~high_byte_enable_n_n_s) | in_hi; // R7 R8 R9
        end
    end

    // checks
    chk_status_null: assert property (@(posedge clk) disable iff (!resetn)
        phase_q == dsaoc_pkg::DSAOC_PH_NULL |=> !status) // R2
        else $error("status high in null phase");
    chk_status_busy: assert property (@(posedge clk) disable iff (!resetn)
        phase_q != dsaoc_pkg::DSAOC_PH_NULL |=> status) // R1
        else $error("status low while converting");
    chk_int_length: assert property (@(posedge clk) disable iff (!resetn)
        phase_q == dsaoc_pkg::DSAOC_PH_INT && tick_q && cnt_q == CW'(INT_COUNTS - 1)
        |=> phase_q == dsaoc_pkg::DSAOC_PH_REF && pol_q == $past(comp_s)) // R20
        else $error("integrate did not end at its count");
    chk_int_bound: assert property (@(posedge clk) disable iff (!resetn)
        phase_q == dsaoc_pkg::DSAOC_PH_INT |-> cnt_q < CW'(INT_COUNTS)) // R20
        else $error("integrate overran");
    chk_halt_point: assert property (@(posedge clk) disable iff (!resetn)
        !run_s && phase_q == dsaoc_pkg::DSAOC_PH_NULL && cnt_q == CW'(FRAME_COUNTS - HALT_EARLY)
        |=> $stable(cnt_q) && phase_q == dsaoc_pkg::DSAOC_PH_NULL) // R18
        else $error("halt point not held");
    chk_test_force: assert property (@(posedge clk) disable iff (!resetn)
        !test_n_s |=> result.magnitude == 12'hfff) // R5
        else $error("test input did not force bits high");
    chk_strobe_gate: assert property (@(posedge clk) disable iff (!resetn)
        direct && ce_n_s |=> !result_lo_oe && !result_hi_oe) // R9
        else $error("outputs enabled with strobe high");
    chk_low_enable: assert property (@(posedge clk) disable iff (!resetn)
        direct && !ce_n_s && !low_byte_enable_n_n_s |=> result_lo_oe) // R6
        else $error("low byte not enabled");
    chk_high_enable: assert property (@(posedge clk) disable iff (!resetn)
        direct && !ce_n_s && !high_byte_enable_n_n_s |=> result_hi_oe) // R7
        else $error("high byte not enabled");
    chk_mode_pins: assert property (@(posedge clk) disable iff (!resetn)
        mode_s |=> chip_strobe_n_oe && low_byte_enable_n_oe && high_byte_enable_n_oe) // R10
        else $error("control pins not driven in handshake mode");
    chk_accept_wait: assert property (@(posedge clk) disable iff (!resetn)
        hs_q == dsaoc_pkg::DSAOC_HS_WAIT_LO && !accept_s |=> hs_q == dsaoc_pkg::DSAOC_HS_WAIT_LO) // R21
        else $error("byte sent without accept");
    chk_pulse_entry: assert property (@(posedge clk) disable iff (!resetn)
        hs_q == dsaoc_pkg::DSAOC_HS_IDLE && mode_s && !mode_prev_q |=> hs_q == dsaoc_pkg::DSAOC_HS_WAIT_HI) // R13
        else $error("mode pulse did not start handshake");

endmodule // dsaoc_ctrl

// File: verification/dsaoc_receiver_model.sv
// far-side receiver model: takes the handshake bytes, throttles with accept
// assumes the bench resolves the two-way pins; flags and load strobe are active low
module dsaoc_receiver_model (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic                     armed,
    input  wire logic                     slow,
    input  wire logic                     strobe_n,
    input  wire logic                     hi_flag_n,
    input  wire logic                     lo_flag_n,
    input  wire dsaoc_pkg::dsaoc_result_t result,
    input  wire logic                     result_hi_oe,
    input  wire logic                     result_lo_oe,
    output logic                          accept,
    output logic                          got_valid,
    output logic [8:0]                    got
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] low_q;
    logic [3:0] busy_q;
    logic       early_q;
    logic [7:0] hi_val;
    logic [7:0] hi_bus;
    logic [7:0] lo_bus;
    assign hi_val = {2'b00, result.sign, result.excess, result.magnitude[11:8]};
    // a floating bus shows the inverse, so a missing enable cannot pass by luck
    assign hi_bus = result_hi_oe ? hi_val : ~hi_val;
    assign lo_bus = result_lo_oe ? result.magnitude[7:0] : ~result.magnitude[7:0];
    // idle or unused: accept stays high
    assign accept = !armed || (busy_q == 4'h0);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_q <= 4'h0;
            busy_q <= 4'h0;
            early_q <= 1'b0;
            got_valid <= 1'b0;
            got <= 9'h000;
        end else begin
            got_valid <= 1'b0;
            if (strobe_n) low_q <= 4'h0;
            else if (low_q != 4'hf) low_q <= low_q + 4'h1;
            // a strobe that starts while accept is low is a byte sent unasked
            if (strobe_n) early_q <= 1'b0;
            else if (low_q == 4'h0) early_q <= (busy_q != 4'h0);
            // sample in the second strobe cycle, when the byte has settled; no flag gives 1ff
            if (armed && !strobe_n && low_q == 4'h1) begin
                got_valid <= 1'b1;
                got <= early_q ? 9'h1fe : !hi_flag_n ? {1'b1, hi_bus} : !lo_flag_n ? {1'b0, lo_bus} : 9'h1ff;
            end
            // with slow set, accept drops as soon as a byte is loaded, so the sender sees it before its next byte
            if (armed && !strobe_n) busy_q <= slow ? 4'hc : 4'h0;
            else if (busy_q != 4'h0) busy_q <= busy_q - 4'h1;
        end
    end
endmodule // dsaoc_receiver_model

// File: verification/tb_dsaoc_ctrl.sv
// testbench of the converter control block: conversions, direct reads, handshake
// assumes the receiver model on the far side; the oscillator pin is made here
module tb_dsaoc_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int FRAME = 64;
    localparam int INTC = 8;
    localparam int DMAX = 16;
    localparam int HALT = 7;
    localparam int XDIV = 4;
    localparam int OSCP = 8;
    logic clk = 1'b0, resetn = 1'b0, osc_buf = 1'b0, osc_sel = 1'b1, run = 1'b1, test_n = 1'b1;
    logic mode = 1'b0, comparator = 1'b0, armed = 1'b0, slow = 1'b0;
    logic host_ce_n = 1'b1, host_lb_n = 1'b1, host_hb_n = 1'b1, lo_oe_p = 1'b0, hi_oe_p = 1'b0;
    logic ce_n, lb_n, hb_n, ce_out, ce_oe, lb_out, lb_oe, hb_out, hb_oe, lo_oe, hi_oe, status, accept, got_valid;
    logic [8:0] got;
    logic s;
    dsaoc_pkg::dsaoc_result_t result;
    logic [8:0] expq[$];
    int mismatches = 0;
    int checks = 0;
    int oc = 0;
    int k, n1, n2;
    always #25 clk = ~clk;
    // a strobe or enable the block does not drive takes the level the host drives
    assign ce_n = ce_oe ? ce_out : host_ce_n;
    assign lb_n = lb_oe ? lb_out : host_lb_n;
    assign hb_n = hb_oe ? hb_out : host_hb_n;
    always @(posedge clk) begin
        #2;
        oc = (oc + 1) % (OSCP / 2);
        if (oc == 0) osc_buf = ~osc_buf;
    end
    dsaoc_ctrl #(.FRAME_COUNTS(FRAME), .INT_COUNTS(INTC), .DEINT_MAX(DMAX), .HALT_EARLY(HALT),
                 .XTAL_DIV(XDIV), .LOAD_CYC(4)) dut (
        .clk(clk), .resetn(resetn), .osc_buf(osc_buf), .osc_sel(osc_sel), .run(run), .test_n(test_n),
        .mode(mode), .comparator(comparator), .accept(accept), .chip_strobe_n_in(ce_n),
        .chip_strobe_n_out(ce_out), .chip_strobe_n_oe(ce_oe), .low_byte_enable_n_in(lb_n),
        .low_byte_enable_n_out(lb_out), .low_byte_enable_n_oe(lb_oe), .high_byte_enable_n_in(hb_n),
        .high_byte_enable_n_out(hb_out), .high_byte_enable_n_oe(hb_oe), .result(result),
        .result_lo_oe(lo_oe), .result_hi_oe(hi_oe), .status(status));
    dsaoc_receiver_model partner (
        .clk(clk), .resetn(resetn), .armed(armed), .slow(slow), .strobe_n(ce_n), .hi_flag_n(hb_n),
        .lo_flag_n(lb_n), .result(result), .result_hi_oe(hi_oe), .result_lo_oe(lo_oe), .accept(accept),
        .got_valid(got_valid), .got(got));
    task automatic fail(input string msg);
        mismatches++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask
    task automatic cmp_byte(input logic [8:0] exp, input logic [8:0] act);
        checks++;
        if (act !== exp) fail($sformatf("byte exp %h got %h", exp, act));
    endtask
    task automatic cmp_val(input logic [15:0] exp, input logic [15:0] act, input string what);
        checks++;
        if (act !== exp) fail($sformatf("%s exp %h got %h", what, exp, act));
    endtask
    task automatic cmp_range(input logic [15:0] v, input int lo, input int hi, input string what);
        checks++;
        if ((v >= lo && v <= hi) !== 1'b1) fail($sformatf("%s %h outside %0d..%0d", what, v, lo, hi));
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wait_status(input logic v, input int lim, output int n);
        n = 0;
        while (status !== v && n < lim) begin
            tick(1);
            n++;
        end
        if (status !== v) fail("status wait timed out");
    endtask
    task automatic wait_drain(input int lim);
        int n;
        n = 0;
        while (expq.size() > 0 && n < lim) begin
            tick(1);
            n++;
        end
        if (expq.size() > 0) fail("bytes missing");
    endtask
    // comparator returns after k reference ticks; k of 0 never returns
    task automatic conv(input logic sg, input int kk);
        int n;
        wait_status(1'b1, 3000, n);
        comparator = sg;
        if (kk > 0) begin
            tick((INTC + kk) * OSCP);
            comparator = ~sg;
        end
        wait_status(1'b0, 3000, n);
        tick(3);
    endtask
    task automatic rd(input logic hi, input logic [8:0] exp);
        expq.push_back(exp);
        host_ce_n = 1'b0;
        if (hi) host_hb_n = 1'b0;
        else host_lb_n = 1'b0;
        tick(5);
        host_ce_n = 1'b1;
        host_hb_n = 1'b1;
        host_lb_n = 1'b1;
        tick(5);
    endtask
    always @(posedge clk) begin
        logic hit;
        logic [8:0] act;
        hit = got_valid;
        act = got;
        if (!armed && hi_oe && !hi_oe_p) begin
            hit = 1'b1;
            act = {3'b100, result.sign, result.excess, result.magnitude[11:8]};
        end
        if (!armed && lo_oe && !lo_oe_p) begin
            hit = 1'b1;
            act = {1'b0, result.magnitude[7:0]};
        end
        hi_oe_p = hi_oe;
        lo_oe_p = lo_oe;
        if (hit && expq.size() == 0) fail("unexpected byte");
        else if (hit) cmp_byte(expq.pop_front(), act);
    end
    initial begin
        repeat (60000) @(posedge clk);
        fail("watchdog expired");
        summarize();
    end
    initial begin
        void'($urandom(32'hb7c114c0));
        tick(6);
        resetn = 1'b1;
        tick(2);
        cmp_val(16'h0000, {10'h000, ce_oe, lb_oe, hb_oe, lo_oe, hi_oe, status}, "after reset");
        s = 1'($urandom_range(1, 0));
        k = $urandom_range(6, 3);
        conv(s, k);
        cmp_range({4'h0, result.magnitude}, k - 2, k + 2, "magnitude");
        cmp_val({14'h0, s, 1'b0}, {14'h0, result.sign, result.excess}, "flags");
        test_n = 1'b0;
        tick(4);
        rd(1'b0, 9'h0ff);
        rd(1'b1, {3'b100, s, 1'b0, 4'hf});
        test_n = 1'b1;
        s = 1'($urandom_range(1, 0));
        conv(s, 0);
        wait_status(1'b1, 3000, n1);
        wait_status(1'b0, 3000, n1);
        wait_status(1'b1, 3000, n2);
        cmp_val(16'(FRAME * OSCP), 16'(n1 + n2), "frame span");
        cmp_range(16'(n1), INTC * OSCP, (INTC + DMAX + 2) * OSCP, "busy span");
        wait_status(1'b0, 3000, n1);
        rd(1'b0, 9'h0ff);
        rd(1'b1, {3'b100, s, 1'b1, 4'hf});
        host_lb_n = 1'b0;
        host_hb_n = 1'b0;
        tick(5);
        cmp_val(16'h0000, {14'h0, lo_oe, hi_oe}, "gated bus");
        host_lb_n = 1'b1;
        host_hb_n = 1'b1;
        wait_status(1'b1, 3000, n1);
        wait_status(1'b0, 3000, n1);
        armed = 1'b1;
        slow = 1'b1;
        expq.push_back({3'b100, s, 1'b1, 4'hf});
        expq.push_back(9'h0ff);
        mode = 1'b1;
        tick(2);
        mode = 1'b0;
        wait_drain(300);
        tick(10);
        wait_status(1'b1, 3000, n1);
        wait_status(1'b0, 3000, n1);
        slow = 1'b0;
        expq.push_back({3'b100, s, 1'b1, 4'hf});
        expq.push_back(9'h0ff);
        s = 1'($urandom_range(1, 0));
        expq.push_back({3'b100, s, 1'b1, 4'hf});
        expq.push_back(9'h0ff);
        mode = 1'b1;
        conv(s, 0);
        wait_drain(300);
        mode = 1'b0;
        tick(10);
        armed = 1'b0;
        run = 1'b0;
        n2 = 0;
        repeat (2 * FRAME * OSCP) begin
            tick(1);
            if (status !== 1'b0) n2++;
        end
        cmp_val(16'h0000, 16'(n2), "halted");
        run = 1'b1;
        wait_status(1'b1, 300, n1);
        cmp_range(16'(n1), (HALT - 1) * OSCP, (HALT + 1) * OSCP + 6, "restart");
        osc_sel = 1'b0;
        wait_status(1'b0, 5000, n1);
        wait_status(1'b1, 5000, n1);
        wait_status(1'b0, 5000, n1);
        wait_status(1'b1, 5000, n2);
        cmp_val(16'(FRAME * XDIV * OSCP), 16'(n1 + n2), "divided frame");
        cmp_val(16'h0000, 16'(expq.size()), "bytes left");
        summarize();
    end
endmodule // tb_dsaoc_ctrl
